// File: rtl/rtcc_top.sv
/*
 Real-time clock control, flags, clock bytes and general RAM behind
 an AXI4-Lite slave, one byte per aligned word (byte address = 4 x index).
 Assumes one clock; reset pin and battery level are asynchronous pins.
*/
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Freeze bit 7 clear advances time each second; set blocks updates; pin reset keeps it.
// - Periodic enable lets periodic flag pull interrupt low; flag sets anyway; pin reset clears.
// - Alarm enable gates alarm flag onto interrupt; only software changes it.
// - Alarm when three time bytes match alarm bytes; 11xxxxxx matches anything.
// - Update-end enable gates its flag; pin reset or freeze write clears it.
// - Square-wave enable drives selected tap out, else pin low; reset clears, power-up sets.
// - Format bit picks binary when 1, BCD when 0; reset leaves it.
// - Hour bit picks 24-hour when 1, 12-hour when 0; reset leaves it.
// - Daylight enable: first April Sunday steps 1:59:59 to 3:00:00.
// - Daylight enable: last October Sunday, first 1:59:59 returns to 1:00:00.
// - Request flag is OR of flag-and-enable pairs; interrupt pin low while set.
// - Reading flag register clears all flags; reset pin low clears them too.
// - Periodic flag sets on selected divider tap edge regardless of enable.
// - Alarm flag sets on time match; with enable raises request and pin.
// - Update-end flag sets after every update cycle.
// - Flag register bits 3..0 read zero, writes ignored.
// - Battery register bit 7 shows backup state, rest zero, not writable.
// - Century byte loads BCD 20 on year 99 to 00, keeps its top bit.
// - General RAM bytes stay readable and writable during updates.
// - Enabling an already set flag asserts the interrupt at once.
// - Flag read returns a stable snapshot; events during it set afterwards.
// - Writing freeze high also clears the update-pending status.
// - Four rate bits pick one of thirteen divider taps or none.
module rtcc_top #(
  parameter int CLK_HZ = 10000000,
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Write address and data
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // Write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // Read address and data
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Device pins
  input  wire logic              reset_pin_n,
  input  wire logic              battery_ok,
  output logic                   irq_n,
  output logic                   square_wave_pin
);
  localparam logic [31:0] ACC_MOD  = 32'(CLK_HZ);
  localparam logic [31:0] ACC_STEP = 32'(rtcc_pkg::OSC_HZ);

  logic [1:0]            pin_meta;
  logic [1:0]            pin_sync;
  logic                  rst_pin;
  logic                  batt;
  logic [31:0]           acc, next_acc;
  logic [14:0]           div, next_div;
  logic                  osc_tick, sec_tick, upd;
  logic [3:0]            tap_idx;
  logic                  tap, tap_q, tap_edge;
  rtcc_pkg::rtcc_ctrl_t  ctrl, next_ctrl;
  rtcc_pkg::rtcc_flags_t flags, next_flags, events;
  logic [3:0]            rs, next_rs;
  logic                  update_pending_status, next_uip, interrupt_request_flag, next_irq_n, next_sqw;
  logic                  aw_held, next_aw_held, aw_ok, next_aw_ok;
  logic [6:0]            aw_idx, next_aw_idx, ar_idx;
  logic                  w_held, next_w_held, wlane, next_wlane;
  logic [7:0]            wbyte, next_wbyte, rd_byte;
  logic                  next_bvalid, next_rvalid, ar_ok, ar_go, wr_go;
  logic [1:0]            next_bresp, next_rresp;
  logic [31:0]           next_rdata;
  logic                  rd_clear, ctrl_wr;
  logic [7:0]            ram [0:rtcc_pkg::RAM_BYTES-1];
  logic                  dst_done, next_dst_done, cent_load, alarm_hit;
  logic [7:0]            sec, mnt, hv, hr, dow, date, mon, yr, dim, h12;
  logic [7:0]            n_sec, n_min, n_hr, n_dow, n_date, n_mon, n_yr;
  logic [7:0]            b_sec, b_min, b_hr, t_sec, t_min, t_hr, h12f;
  function automatic logic [7:0] to_bin(input logic [7:0] v, input logic bin);
    return bin ? v : {4'h0, v[7:4]} * 8'h0a + {4'h0, v[3:0]};
  endfunction
  function automatic logic [7:0] to_fmt(input logic [7:0] v, input logic bin);
    return bin ? v : {4'(v / 8'h0a), 4'(v % 8'h0a)};
  endfunction
  function automatic logic hit(input logic [7:0] t, input logic [7:0] a);
    return (a[7:6] == rtcc_pkg::DONT_CARE) || (t == a);
  endfunction
  // Pins are asynchronous; only the second stage is read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= 2'h3;
      pin_sync <= 2'h3;
    end else begin
      pin_meta <= {battery_ok, reset_pin_n};
      pin_sync <= pin_meta;
    end
  end
  assign rst_pin = !pin_sync[0];
  assign batt    = pin_sync[1];
  // Fractional divider makes the oscillator ticks from the bus clock
  always_comb begin
    next_acc = acc + ACC_STEP;
    osc_tick = 1'b0;
    if (next_acc >= ACC_MOD) begin
      next_acc = next_acc - ACC_MOD;
      osc_tick = 1'b1;
    end
    next_div = osc_tick ? div + 15'h0001 : div;
    sec_tick = osc_tick && (div == 15'h7fff);
    upd      = sec_tick && !ctrl.update_freeze;
    tap_idx  = (rs <= 4'h2) ? rs + rtcc_pkg::TAP_LOW_OFS : rs - rtcc_pkg::TAP_HIGH_OFS;
    tap      = (rs != rtcc_pkg::RATE_NONE) && div[tap_idx];
    tap_edge = tap && !tap_q;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc   <= 32'h0;
      div   <= 15'h0;
      tap_q <= 1'b0;
    end else begin
      acc   <= next_acc;
      div   <= next_div;
      tap_q <= tap;
    end
  end
  // Bus slave, control, flags and pin outputs
  assign awready = !aw_held;
  assign wready  = !w_held;
  assign arready = !rvalid;
  assign ar_go   = arvalid && arready;
  assign ar_idx  = araddr[rtcc_pkg::ADDR_LSB +: rtcc_pkg::IDX_W];
  assign ar_ok   = araddr[ADDR_W-1:rtcc_pkg::ADDR_LSB+rtcc_pkg::IDX_W] == '0;
  assign wr_go   = aw_held && w_held && !bvalid;
  assign ctrl_wr = wr_go && aw_ok && wlane && (aw_idx == rtcc_pkg::IDX_CTRL);
  assign interrupt_request_flag    = (flags.periodic_flag && ctrl.periodic_int_enable)
                 || (flags.alarm_flag && ctrl.alarm_int_enable)
                 || (flags.update_end_flag && ctrl.update_end_int_enable);
  always_comb begin
    next_aw_held = aw_held;
    next_aw_idx  = aw_idx;
    next_aw_ok   = aw_ok;
    next_w_held  = w_held;
    next_wbyte   = wbyte;
    next_wlane   = wlane;
    next_bvalid  = bvalid && !bready;
    next_bresp   = bresp;
    next_rvalid  = rvalid && !rready;
    next_rdata   = rdata;
    next_rresp   = rresp;
    next_ctrl    = ctrl;
    next_rs      = rs;
    next_uip     = !ctrl.update_freeze && (div >= rtcc_pkg::UIP_START);
    rd_clear     = 1'b0;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_idx  = awaddr[rtcc_pkg::ADDR_LSB +: rtcc_pkg::IDX_W];
      next_aw_ok   = awaddr[ADDR_W-1:rtcc_pkg::ADDR_LSB+rtcc_pkg::IDX_W] == '0;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_wbyte  = wdata[7:0];
      next_wlane  = wstrb[0];
    end
    if (wr_go) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = aw_ok ? rtcc_pkg::RESP_OKAY : rtcc_pkg::RESP_SLVERR;
    end
    // Flag and battery writes fall through and are dropped
    if (wr_go && aw_ok && wlane && aw_idx == rtcc_pkg::IDX_RATE) begin
      next_rs = wbyte[3:0];
    end
    if (ctrl_wr) begin
      next_ctrl = wbyte;
      if (wbyte[7]) begin
        next_ctrl.update_end_int_enable = 1'b0;
        next_uip = 1'b0;
      end
    end
    case (ar_idx)
      rtcc_pkg::IDX_RATE:  rd_byte = {update_pending_status, 3'h0, rs};
      rtcc_pkg::IDX_CTRL:  rd_byte = ctrl;
      rtcc_pkg::IDX_FLAGS: rd_byte = {interrupt_request_flag, flags, 4'h0};
      rtcc_pkg::IDX_BATT:  rd_byte = {batt, 7'h00};
      default:             rd_byte = ram[ar_idx];
    endcase
    if (ar_go) begin
      next_rvalid = 1'b1;
      next_rresp  = ar_ok ? rtcc_pkg::RESP_OKAY : rtcc_pkg::RESP_SLVERR;
      next_rdata  = ar_ok ? {24'h0, rd_byte} : 32'h0;
      rd_clear    = ar_ok && (ar_idx == rtcc_pkg::IDX_FLAGS);
    end
    events.periodic_flag   = tap_edge;
    events.alarm_flag      = sec_tick && alarm_hit;
    events.update_end_flag = sec_tick;
    // New events win over the read clear, so none is lost
    next_flags = (rd_clear ? '0 : flags) | events;
    if (rst_pin) begin
      next_flags = '0;
      next_ctrl.periodic_int_enable   = 1'b0;
      next_ctrl.update_end_int_enable = 1'b0;
      next_ctrl.square_wave_enable    = 1'b0;
    end
    next_irq_n = !interrupt_request_flag;
    next_sqw   = ctrl.square_wave_enable && tap;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held         <= 1'b0;
      aw_idx          <= 7'h00;
      aw_ok           <= 1'b0;
      w_held          <= 1'b0;
      wbyte           <= 8'h00;
      wlane           <= 1'b0;
      bvalid          <= 1'b0;
      bresp           <= rtcc_pkg::RESP_OKAY;
      rvalid          <= 1'b0;
      rdata           <= 32'h0;
      rresp           <= rtcc_pkg::RESP_OKAY;
      ctrl            <= rtcc_pkg::CTRL_POR;
      rs              <= rtcc_pkg::RATE_POR;
      update_pending_status             <= 1'b0;
      flags           <= '0;
      irq_n           <= 1'b1;
      square_wave_pin <= 1'b0;
    end else begin
      aw_held         <= next_aw_held;
      aw_idx          <= next_aw_idx;
      aw_ok           <= next_aw_ok;
      w_held          <= next_w_held;
      wbyte           <= next_wbyte;
      wlane           <= next_wlane;
      bvalid          <= next_bvalid;
      bresp           <= next_bresp;
      rvalid          <= next_rvalid;
      rdata           <= next_rdata;
      rresp           <= next_rresp;
      ctrl            <= next_ctrl;
      rs              <= next_rs;
      update_pending_status             <= next_uip;
      flags           <= next_flags;
      irq_n           <= next_irq_n;
      square_wave_pin <= next_sqw;
    end
  end
  // Time arithmetic runs in binary whatever the stored format
  always_comb begin
    sec  = to_bin(ram[rtcc_pkg::IDX_SEC], ctrl.binary_format_select);
    mnt  = to_bin(ram[rtcc_pkg::IDX_MIN], ctrl.binary_format_select);
    hv   = to_bin({1'b0, ram[rtcc_pkg::IDX_HR][6:0]}, ctrl.binary_format_select);
    hr   = ctrl.hour_24_select ? hv : ((hv == rtcc_pkg::NOON) ? 8'h00 : hv)
         + (ram[rtcc_pkg::IDX_HR][7] ? rtcc_pkg::NOON : 8'h00);
    dow  = ram[rtcc_pkg::IDX_DOW];
    date = to_bin(ram[rtcc_pkg::IDX_DATE], ctrl.binary_format_select);
    mon  = to_bin(ram[rtcc_pkg::IDX_MON], ctrl.binary_format_select);
    yr   = to_bin(ram[rtcc_pkg::IDX_YEAR], ctrl.binary_format_select);
    dim  = (mon == rtcc_pkg::FEBRUARY) ? ((yr[1:0] == 2'h0) ? 8'h1d : 8'h1c)
         : (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h0b) ? 8'h1e : 8'h1f;
    n_sec = sec + 8'h01;
    n_min = mnt;
    n_hr = hr;
    n_dow = dow;
    n_date = date;
    n_mon = mon;
    n_yr = yr;
    cent_load = 1'b0;
    next_dst_done = dst_done;
    if (n_sec == rtcc_pkg::SIXTY) begin
      n_sec = 8'h00;
      n_min = mnt + 8'h01;
      if (n_min == rtcc_pkg::SIXTY) begin
        n_min = 8'h00;
        n_hr = hr + 8'h01;
        if (n_hr == rtcc_pkg::HRS_DAY) begin
          n_hr = 8'h00;
          next_dst_done = 1'b0;
          n_dow = (dow >= rtcc_pkg::LAST_DOW) ? 8'h01 : dow + 8'h01;
          n_date = date + 8'h01;
          if (n_date > dim) begin
            n_date = 8'h01;
            n_mon = mon + 8'h01;
            if (n_mon > rtcc_pkg::MONTHS) begin
              n_mon = 8'h01;
              n_yr = yr + 8'h01;
              if (n_yr == rtcc_pkg::YEARS) begin
                n_yr = 8'h00;
                cent_load = 1'b1;
              end
            end
          end
        end
      end
    end
    if (ctrl.daylight_saving_enable && dow == rtcc_pkg::SUNDAY && hr == rtcc_pkg::DST_HOUR
        && mnt == rtcc_pkg::SIXTY - 8'h01 && sec == rtcc_pkg::SIXTY - 8'h01) begin
      if (mon == rtcc_pkg::APRIL && date <= rtcc_pkg::WEEK1_END) begin
        n_hr = rtcc_pkg::SPRING_HOUR;
        n_min = 8'h00;
        n_sec = 8'h00;
      end else if (mon == rtcc_pkg::OCTOBER && date >= rtcc_pkg::LASTWK_BEG && !dst_done) begin
        n_hr = rtcc_pkg::DST_HOUR;
        n_min = 8'h00;
        n_sec = 8'h00;
        next_dst_done = 1'b1;
      end
    end
    if (!upd) begin
      next_dst_done = dst_done;
    end
    h12 = (n_hr == 8'h00) ? rtcc_pkg::NOON : (n_hr > rtcc_pkg::NOON) ? n_hr - rtcc_pkg::NOON : n_hr;
    h12f = to_fmt(h12, ctrl.binary_format_select);
    b_sec = to_fmt(n_sec, ctrl.binary_format_select);
    b_min = to_fmt(n_min, ctrl.binary_format_select);
    b_hr = ctrl.hour_24_select ? to_fmt(n_hr, ctrl.binary_format_select)
         : {n_hr >= rtcc_pkg::NOON, h12f[6:0]};
    // Frozen time is still checked against the alarm each second
    t_sec = upd ? b_sec : ram[rtcc_pkg::IDX_SEC];
    t_min = upd ? b_min : ram[rtcc_pkg::IDX_MIN];
    t_hr = upd ? b_hr : ram[rtcc_pkg::IDX_HR];
    alarm_hit = hit(t_sec, ram[rtcc_pkg::IDX_SEC_ALM]) && hit(t_min, ram[rtcc_pkg::IDX_MIN_ALM])
              && hit(t_hr, ram[rtcc_pkg::IDX_HR_ALM]);
  end
  // Bus writes land after the update, so software always has the last word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dst_done <= 1'b0;
      for (int i = 0; i < rtcc_pkg::RAM_BYTES; i++) begin
        ram[i] <= 8'h00;
      end
    end else begin
      dst_done <= next_dst_done;
      if (upd) begin
        ram[rtcc_pkg::IDX_SEC]  <= b_sec;
        ram[rtcc_pkg::IDX_MIN]  <= b_min;
        ram[rtcc_pkg::IDX_HR]   <= b_hr;
        ram[rtcc_pkg::IDX_DOW]  <= n_dow;
        ram[rtcc_pkg::IDX_DATE] <= to_fmt(n_date, ctrl.binary_format_select);
        ram[rtcc_pkg::IDX_MON]  <= to_fmt(n_mon, ctrl.binary_format_select);
        ram[rtcc_pkg::IDX_YEAR] <= to_fmt(n_yr, ctrl.binary_format_select);
        if (cent_load) begin
          ram[rtcc_pkg::IDX_CENT] <= {ram[rtcc_pkg::IDX_CENT][7], rtcc_pkg::CENT_LOAD};
        end
      end
      if (wr_go && aw_ok && wlane && (aw_idx < rtcc_pkg::IDX_RATE || aw_idx > rtcc_pkg::IDX_BATT)) begin
        ram[aw_idx] <= wbyte;
      end
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_irq_pin_flag: assert property (1'b1 |=> irq_n == !$past(interrupt_request_flag))
    else $error("interrupt pin does not follow request flag");
  a_freeze_holds_time: assert property ((ctrl.update_freeze && !wr_go) |=> $stable(ram[0]))
    else $error("seconds changed while frozen");
  a_tap_sets_pf: assert property ((tap_edge && !rst_pin) |=> flags.periodic_flag)
    else $error("periodic flag missed a tap edge");
  a_alarm_sets_af: assert property ((sec_tick && alarm_hit && !rst_pin) |=> flags.alarm_flag)
    else $error("alarm flag missed a match");
  a_read_clears_flags: assert property ((rd_clear && !tap_edge && !sec_tick) |=> flags == '0)
    else $error("flag read did not clear flags");
  a_flag_read_snap: assert property (rd_clear |=> rdata == {24'h0, $past(interrupt_request_flag), $past(flags), 4'h0})
    else $error("flag read data not the pre-clear snapshot");
  a_batt_read_value: assert property ((ar_go && ar_ok && ar_idx == 7'h0d) |=> rdata == {24'h0, $past(batt), 7'h00})
    else $error("battery register read wrong");
  a_freeze_clears_uie: assert property ((ctrl_wr && wbyte[7]) |=> !ctrl.update_end_int_enable && !update_pending_status)
    else $error("freeze write left update enable or pending status set");
  a_sqw_low_off: assert property (!ctrl.square_wave_enable |=> !square_wave_pin)
    else $error("square wave pin high while disabled");
  a_reset_pin_clear: assert property (rst_pin |=> flags == '0 && !ctrl.periodic_int_enable
                                      && !ctrl.square_wave_enable)
    else $error("reset pin did not clear enables and flags");
  a_century_load: assert property ((upd && cent_load && !wr_go) |=> ram[7'h32][6:0] == 7'h20)
    else $error("century byte not loaded on year rollover");
endmodule // rtcc_top
`default_nettype wire

// File: rtl/rtcc_pkg.sv
/*
 Shared constants and types of the real-time clock control block:
 register indices, field layouts, reset values and timing counts.
 Assumes a 32.768 kHz time base made from the bus clock.
*/
`default_nettype none
package rtcc_pkg;
  localparam int OSC_HZ         = 32768;
  localparam int UIP_LEAD_US    = 244;
  localparam int UIP_LEAD_TICKS = (UIP_LEAD_US * OSC_HZ + 999999) / 1000000;
  localparam logic [14:0] UIP_START = 15'(OSC_HZ - UIP_LEAD_TICKS);
  localparam logic [3:0] TAP_LOW_OFS  = 4'h5;
  localparam logic [3:0] TAP_HIGH_OFS = 4'h2;
  localparam logic [3:0] RATE_NONE    = 4'h0;
  localparam int IDX_W     = 7;
  localparam int RAM_BYTES = 128;
  localparam int ADDR_LSB  = 2;
  localparam logic [6:0] IDX_SEC     = 7'h00;
  localparam logic [6:0] IDX_SEC_ALM = 7'h01;
  localparam logic [6:0] IDX_MIN     = 7'h02;
  localparam logic [6:0] IDX_MIN_ALM = 7'h03;
  localparam logic [6:0] IDX_HR      = 7'h04;
  localparam logic [6:0] IDX_HR_ALM  = 7'h05;
  localparam logic [6:0] IDX_DOW     = 7'h06;
  localparam logic [6:0] IDX_DATE    = 7'h07;
  localparam logic [6:0] IDX_MON     = 7'h08;
  localparam logic [6:0] IDX_YEAR    = 7'h09;
  localparam logic [6:0] IDX_RATE    = 7'h0a;
  localparam logic [6:0] IDX_CTRL    = 7'h0b;
  localparam logic [6:0] IDX_FLAGS   = 7'h0c;
  localparam logic [6:0] IDX_BATT    = 7'h0d;
  localparam logic [6:0] IDX_CENT    = 7'h32;
  localparam logic [7:0] CTRL_POR    = 8'h08;
  localparam logic [3:0] RATE_POR    = 4'h0;
  localparam logic [6:0] CENT_LOAD   = 7'h20;
  localparam logic [1:0] DONT_CARE   = 2'h3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] SIXTY       = 8'h3c;
  localparam logic [7:0] HRS_DAY     = 8'h18;
  localparam logic [7:0] NOON        = 8'h0c;
  localparam logic [7:0] LAST_DOW    = 8'h07;
  localparam logic [7:0] MONTHS      = 8'h0c;
  localparam logic [7:0] YEARS       = 8'h64;
  localparam logic [7:0] SUNDAY      = 8'h01;
  localparam logic [7:0] APRIL       = 8'h04;
  localparam logic [7:0] OCTOBER     = 8'h0a;
  localparam logic [7:0] FEBRUARY    = 8'h02;
  localparam logic [7:0] DST_HOUR    = 8'h01;
  localparam logic [7:0] SPRING_HOUR = 8'h03;
  localparam logic [7:0] WEEK1_END   = 8'h07;
  localparam logic [7:0] LASTWK_BEG  = 8'h19;
  typedef struct packed {
    logic update_freeze;
    logic periodic_int_enable;
    logic alarm_int_enable;
    logic update_end_int_enable;
    logic square_wave_enable;
    logic binary_format_select;
    logic hour_24_select;
    logic daylight_saving_enable;
  } rtcc_ctrl_t;
  typedef struct packed {
    logic periodic_flag;
    logic alarm_flag;
    logic update_end_flag;
  } rtcc_flags_t;
endpackage
`default_nettype wire

// File: dv/rtcc_axi_host.sv
/*
 Host bus master for the clock control block: one AXI4-Lite transfer at a time.
 Assumes the slave answers on its own schedule; only the bench timeout ends a wait.
*/
`timescale 1ns/1ps
`default_nettype none
module rtcc_axi_host (
  // Clock
  input  wire logic        aclk,
  // Write channels
  output logic [11:0]      awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  // Read channels
  output logic [11:0]      araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  assign wstrb  = 4'hf;
  // Answers are always accepted, so back-to-back calls never toggle ready
  assign bready = 1'b1;
  assign rready = 1'b1;
  initial begin
    {awaddr, awvalid, wdata, wvalid} = '0;
    {araddr, arvalid} = '0;
  end
  // Every handshake is judged at the rising edge that completes it
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                      output logic [31:0] q, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    if (w) begin
      awaddr  <= a;
      wdata   <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
    end else begin
      araddr  <= a;
      arvalid <= 1'b1;
    end
    while (!done) begin
      @(posedge aclk);
      // Released payload is scrambled so nothing leans on a stale value
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr  <= ~awaddr;
      end
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr  <= ~araddr;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata  <= ~wdata;
      end
      if (w ? bvalid : rvalid) begin
        q    = rdata;
        resp = w ? bresp : rresp;
        done = 1'b1;
      end
    end
  endtask
endmodule // rtcc_axi_host
`default_nettype wire

// File: dv/rtcc_tb_top.sv
/*
 Bench top for the clock control block: register traffic, pins, one second of time.
 Assumes CLK_HZ of 32768, so one time base tick per clock.
*/
`timescale 1ns/1ps
`default_nettype none
module rtcc_tb_top;
  logic        aclk, aresetn, reset_pin_n, battery_ok, irq_n, square_wave_pin, sq_hi, sq_lo;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, q;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic [6:0]  ix [12];
  logic [7:0]  shadow [128];
  logic [7:0]  tinit [10] = '{8'h59, 8'hc5, 8'h59, 8'hd0, 8'h23, 8'hff, 8'h05, 8'h31, 8'h12, 8'h99};
  int          fails = 0;
  int          n_checks = 0;
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  rtcc_top #(.CLK_HZ(32768), .ADDR_W(12)) u_rtcc_top (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .reset_pin_n, .battery_ok, .irq_n, .square_wave_pin);
  rtcc_axi_host u_rtcc_axi_host (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    chk8({7'h0, got}, {7'h0, exp});
  endtask
  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    u_rtcc_axi_host.xfer(1'b1, {3'h0, i, 2'h0}, d, q, rsp);
    chk8({6'h0, rsp}, {6'h0, rtcc_pkg::RESP_OKAY});
  endtask
  task automatic rd(input logic [6:0] i);
    u_rtcc_axi_host.xfer(1'b0, {3'h0, i, 2'h0}, 8'h00, q, rsp);
  endtask
  task automatic rd_chk(input logic [6:0] i, input logic [7:0] e);
    rd(i);
    chk8(q[7:0], e);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Pin reset must outlast the two-stage synchroniser
  task automatic pin_reset();
    reset_pin_n <= 1'b0;
    wait_cyc(6);
    reset_pin_n <= 1'b1;
    wait_cyc(3);
  endtask
  function automatic logic [7:0] after_pin(input logic [7:0] c);
    return c & 8'ha7;
  endfunction
  function automatic logic [7:0] after_freeze(input logic [7:0] c);
    return (c | 8'h80) & 8'hef;
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    wait_cyc(60000);
    fails++;
    $display("watchdog expired at %0t", $time);
    print_verdict();
  end
  initial begin
    aresetn = 1'b0;
    reset_pin_n = 1'b1;
    battery_ok = 1'b1;
    void'($urandom(32'h55ed4b63));
    wait_cyc(5);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(rtcc_pkg::IDX_CTRL, rtcc_pkg::CTRL_POR);
    wr(rtcc_pkg::IDX_FLAGS, 8'hff);
    rd_chk(rtcc_pkg::IDX_FLAGS, 8'h00);
    wr(rtcc_pkg::IDX_BATT, 8'h00);
    rd_chk(rtcc_pkg::IDX_BATT, 8'h80);
    battery_ok <= 1'b0;
    wait_cyc(4);
    rd_chk(rtcc_pkg::IDX_BATT, 8'h00);
    battery_ok <= 1'b1;
    u_rtcc_axi_host.xfer(1'b1, 12'h400, 8'h55, q, rsp);
    chk8({6'h0, rsp}, {6'h0, rtcc_pkg::RESP_SLVERR});
    u_rtcc_axi_host.xfer(1'b0, 12'h400, 8'h00, q, rsp);
    chk8({6'h0, rsp}, {6'h0, rtcc_pkg::RESP_SLVERR});
    $display("test 1 done");
    for (int i = 0; i < 12; i++) begin
      ix[i] = 7'h0e + 7'($urandom % 36);
      shadow[ix[i]] = 8'($urandom);
      wr(ix[i], shadow[ix[i]]);
    end
    for (int i = 0; i < 12; i++) rd_chk(ix[i], shadow[ix[i]]);
    $display("test 2 done");
    // Fastest tap sets the periodic flag every four ticks
    wr(rtcc_pkg::IDX_CTRL, 8'h02);
    wr(rtcc_pkg::IDX_RATE, 8'h03);
    wait_cyc(12);
    chk_pin(irq_n, 1'b1);
    rd_chk(rtcc_pkg::IDX_FLAGS, 8'h40);
    wr(rtcc_pkg::IDX_CTRL, 8'h42);
    wait_cyc(6);
    chk_pin(irq_n, 1'b0);
    rd_chk(rtcc_pkg::IDX_FLAGS, 8'hc0);
    // Fastest tap has a four-tick period, so four samples see both levels
    wr(rtcc_pkg::IDX_CTRL, 8'h4a);
    sq_hi = 1'b0;
    sq_lo = 1'b0;
    repeat (4) begin
      @(posedge aclk);
      sq_hi = sq_hi | square_wave_pin;
      sq_lo = sq_lo | !square_wave_pin;
    end
    chk_pin(sq_hi, 1'b1);
    chk_pin(sq_lo, 1'b1);
    wr(rtcc_pkg::IDX_RATE, rtcc_pkg::RATE_NONE);
    wr(rtcc_pkg::IDX_CTRL, 8'h02);
    rd(rtcc_pkg::IDX_FLAGS);
    rd_chk(rtcc_pkg::IDX_FLAGS, 8'h00);
    chk_pin(irq_n, 1'b1);
    $display("test 3 done");
    wr(rtcc_pkg::IDX_CTRL, 8'h82);
    for (int i = 0; i < 10; i++) wr(7'(i), tinit[i]);
    wr(rtcc_pkg::IDX_CENT, 8'h85);
    wr(rtcc_pkg::IDX_CTRL, 8'h02);
    rd(rtcc_pkg::IDX_FLAGS);
    wait_cyc(32768);
    wr(rtcc_pkg::IDX_CTRL, 8'h22);
    wait_cyc(3);
    chk_pin(irq_n, 1'b0);
    rd_chk(rtcc_pkg::IDX_FLAGS, 8'hb0);
    rd_chk(rtcc_pkg::IDX_SEC, 8'h00);
    rd_chk(rtcc_pkg::IDX_YEAR, 8'h00);
    rd_chk(rtcc_pkg::IDX_CENT, 8'ha0);
    wait_cyc(3);
    chk_pin(irq_n, 1'b1);
    $display("test 4 done");
    wr(rtcc_pkg::IDX_CTRL, 8'h7f);
    pin_reset();
    rd_chk(rtcc_pkg::IDX_CTRL, after_pin(8'h7f));
    chk_pin(square_wave_pin, 1'b0);
    wr(rtcc_pkg::IDX_CTRL, 8'h7f);
    wr(rtcc_pkg::IDX_CTRL, 8'hff);
    rd_chk(rtcc_pkg::IDX_CTRL, after_freeze(8'hff));
    rd_chk(rtcc_pkg::IDX_RATE, 8'h00);
    pin_reset();
    rd_chk(rtcc_pkg::IDX_CTRL, after_pin(after_freeze(8'hff)));
    rd_chk(rtcc_pkg::IDX_FLAGS, 8'h00);
    $display("test 5 done");
    print_verdict();
  end
endmodule // rtcc_tb_top
`default_nettype wire
